// *** include/prs_pkg.sv ***
// shared constants for the pin reset state and strap loader
package prs_pkg;
	// port counts and widths
	localparam int PRS_DIFF_PORTS = 16;
	localparam int PRS_SE_PORTS = 2;
	localparam int PRS_GPIO_W = 24;
	localparam int PRS_DIV_W = 6;
	localparam int PRS_SEL_W = 3;
	localparam int PRS_PORT_ID_W = 5;
	localparam int PRS_TEST_W = 2;
	localparam int PRS_ADDR_W = 8;
	localparam int PRS_DATA_W = 32;

	// link clock select code that bypasses the pll, lock then reads constant one
	localparam logic [PRS_SEL_W-1:0] PRS_SEL_BYPASS = 3'h0;

	// configuration port and the two ports that may still reach it when guarded
	localparam logic [PRS_PORT_ID_W-1:0] PRS_CFG_PORT = 5'h00;
	localparam logic [PRS_PORT_ID_W-1:0] PRS_TRUSTED_PORT_A = 5'h01;
	localparam logic [PRS_PORT_ID_W-1:0] PRS_TRUSTED_PORT_B = 5'h02;

	// pin levels held during reset
	localparam logic [PRS_DIFF_PORTS-1:0] PRS_RST_DIFF_POS = 16'h0000;
	localparam logic [PRS_DIFF_PORTS-1:0] PRS_RST_DIFF_NEG = 16'hffff;
	localparam logic [PRS_SE_PORTS-1:0] PRS_RST_SE_OUT = 2'h0;
	localparam logic [PRS_SE_PORTS-1:0] PRS_RST_SE_EN = 2'h3;
	localparam logic [PRS_GPIO_W-1:0] PRS_RST_GPIO_OE = 24'h000000;

	// register offsets (byte addresses)
	localparam logic [PRS_ADDR_W-1:0] PRS_OFS_FEATURE = 8'h00;
	localparam logic [PRS_ADDR_W-1:0] PRS_OFS_DIVISOR = 8'h04;
	localparam logic [PRS_ADDR_W-1:0] PRS_OFS_STATUS = 8'h08;

	// feature register bit positions
	localparam int PRS_FB_SPILL = 0;
	localparam int PRS_FB_START_REQ = 1;
	localparam int PRS_FB_AUTO_DISC = 2;
	localparam int PRS_FB_PLUG_PLAY = 3;
	localparam int PRS_FB_STATIC = 4;

	// divisor register field positions
	localparam int PRS_DB_INIT_LSB = 0;
	localparam int PRS_DB_RUN_LSB = 8;

	// status register bit positions
	localparam int PRS_SB_LOCK = 0;
	localparam int PRS_SB_GUARD = 1;
	localparam int PRS_SB_IRQ = 2;
	localparam int PRS_SB_TEST_LSB = 4;
	localparam int PRS_SB_SEL_LSB = 8;
	localparam int PRS_SB_DIV_LSB = 16;

	// strap vector layout: divisor, spill, start, auto, pnp, static, guard
	localparam int PRS_STRAP_W = PRS_DIV_W + 6;
endpackage : prs_pkg

// *** design/prs_sync2.sv ***
// two flip-flop synchroniser for level inputs arriving from pins
`timescale 1ns/10ps
module prs_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} prs_sync_t;

	prs_sync_t state;
	prs_sync_t next_state;

	// meta is only ever copied into stable, nothing else looks at it
	always_comb begin
		next_state = state;
		next_state.meta = async_in;
		next_state.stable = state.meta;
		if (reset) begin
			next_state = '0;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	assign sync_out = state.stable;
endmodule : prs_sync2

// *** design/prs_reset_sync.sv ***
// internal reset generator: asserts at once from the pin, releases on the clock
`timescale 1ns/10ps
module prs_reset_sync (
	input wire logic clk,
	input wire logic sys_reset_low,
	output logic int_reset
);
	typedef struct packed {
		logic release_meta;
		logic release_done;
	} prs_rst_t;

	prs_rst_t state;
	prs_rst_t next_state;

	// a one walks in after the pin rises; second stage only reads the first
	always_comb begin
		next_state.release_meta = 1'b1;
		next_state.release_done = state.release_meta;
	end

	// async clear loads constants only, so the pin can never glitch a data path
	always_ff @(posedge clk or negedge sys_reset_low) begin
		if (!sys_reset_low) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign int_reset = ~state.release_done;
endmodule : prs_reset_sync

// *** design/prs_pin_reset.sv ***
// pin reset states, strap capture and reset-default registers of the router
`timescale 1ns/10ps
module prs_pin_reset
	import prs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	// board pins
	input wire logic sys_reset_low,
	input wire logic [PRS_SEL_W-1:0] link_clock_select,
	input wire logic [PRS_TEST_W-1:0] test_mode_enable,
	input wire logic config_port_guard,
	input wire logic [PRS_DIV_W-1:0] link_divisor_strap,
	input wire logic spill_strap,
	input wire logic plug_play_strap,
	input wire logic start_on_request_strap,
	input wire logic auto_disconnect_strap,
	input wire logic static_route_strap,
	input wire logic pll_locked,
	output logic lock_out,
	output logic irq_out,
	// differential links, core side request and pin side result
	input wire logic [PRS_DIFF_PORTS-1:0] core_data_pos,
	input wire logic [PRS_DIFF_PORTS-1:0] core_strobe_pos,
	output logic [PRS_DIFF_PORTS-1:0] link_data_out_pos,
	output logic [PRS_DIFF_PORTS-1:0] link_data_out_neg,
	output logic [PRS_DIFF_PORTS-1:0] link_strobe_out_pos,
	output logic [PRS_DIFF_PORTS-1:0] link_strobe_out_neg,
	// single-ended links
	input wire logic [PRS_SE_PORTS-1:0] core_se_data,
	input wire logic [PRS_SE_PORTS-1:0] core_se_strobe,
	input wire logic [PRS_SE_PORTS-1:0] core_se_enable,
	output logic [PRS_SE_PORTS-1:0] se_data_out,
	output logic [PRS_SE_PORTS-1:0] se_strobe_out,
	output logic [PRS_SE_PORTS-1:0] se_xcvr_enable,
	// general pins: mux request in, pin drive out
	input wire logic [PRS_GPIO_W-1:0] mux_gpio_out,
	input wire logic [PRS_GPIO_W-1:0] mux_gpio_oe,
	output logic [PRS_GPIO_W-1:0] gpio_out,
	output logic [PRS_GPIO_W-1:0] gpio_oe,
	// events from the router core
	input wire logic error_event,
	input wire logic status_event,
	input wire logic irq_ack,
	// accesses arriving for the configuration port
	input wire logic cfg_access_valid,
	input wire logic [PRS_PORT_ID_W-1:0] cfg_access_src,
	output logic cfg_access_grant,
	output logic cfg_access_refused,
	// feature defaults handed to the link ports and router
	output logic [PRS_DIV_W-1:0] init_divisor,
	output logic [PRS_DIV_W-1:0] run_divisor,
	output logic spill_enable,
	output logic start_on_request_enable,
	output logic auto_disconnect_enable,
	output logic plug_play_enable,
	output logic static_route_enable,
	output logic device_in_reset,
	// register port
	input wire logic [PRS_ADDR_W-1:0] reg_addr,
	input wire logic [PRS_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [PRS_DATA_W-1:0] reg_rdata
);
	typedef struct packed {
		logic [PRS_DIV_W-1:0] init_div;
		logic [PRS_DIV_W-1:0] run_div;
		logic spill;
		logic start_req;
		logic auto_disc;
		logic plug_play;
		logic static_route;
		logic lock;
		logic irq;
		logic [PRS_DIFF_PORTS-1:0] data_pos;
		logic [PRS_DIFF_PORTS-1:0] data_neg;
		logic [PRS_DIFF_PORTS-1:0] strobe_pos;
		logic [PRS_DIFF_PORTS-1:0] strobe_neg;
		logic [PRS_SE_PORTS-1:0] se_data;
		logic [PRS_SE_PORTS-1:0] se_strobe;
		logic [PRS_SE_PORTS-1:0] se_enable;
		logic [PRS_GPIO_W-1:0] gpio_data;
		logic [PRS_GPIO_W-1:0] gpio_dir;
		logic [PRS_DATA_W-1:0] rdata;
	} prs_state_t;

	prs_state_t state;
	prs_state_t next_state;

	logic int_reset;
	logic rst_any;
	logic [PRS_STRAP_W-1:0] strap_raw;
	logic [PRS_STRAP_W-1:0] strap_sync;
	logic [PRS_SEL_W-1:0] sel_sync;
	logic [PRS_TEST_W-1:0] test_sync;
	logic lock_sync;
	logic guard;
	logic [PRS_DIV_W-1:0] div_strap;
	logic trusted_src;

	// internal reset from the pin
	prs_reset_sync u_reset_sync (
		.clk(clk),
		.sys_reset_low(sys_reset_low),
		.int_reset(int_reset)
	);

	// every strap is a pin, so all of them pass two flops before use
	assign strap_raw = {config_port_guard, static_route_strap, plug_play_strap,
		auto_disconnect_strap, start_on_request_strap, spill_strap, link_divisor_strap};

	prs_sync2 #(
		.W(PRS_STRAP_W)
	) u_strap_sync (
		.clk(clk),
		.reset(reset),
		.async_in(strap_raw),
		.sync_out(strap_sync)
	);

	prs_sync2 #(
		.W(PRS_SEL_W)
	) u_sel_sync (
		.clk(clk),
		.reset(reset),
		.async_in(link_clock_select),
		.sync_out(sel_sync)
	);

	// test enables are only reported, the system keeps them low
	prs_sync2 #(
		.W(PRS_TEST_W)
	) u_test_sync (
		.clk(clk),
		.reset(reset),
		.async_in(test_mode_enable),
		.sync_out(test_sync)
	);

	// lock comes from the pll on its own clock
	prs_sync2 #(
		.W(1)
	) u_lock_sync (
		.clk(clk),
		.reset(reset),
		.async_in(pll_locked),
		.sync_out(lock_sync)
	);

	assign rst_any = reset | int_reset;
	assign div_strap = strap_sync[PRS_DIV_W-1:0];
	assign guard = strap_sync[PRS_DIV_W+5];

	// ports 1 and 2 stay allowed even with the guard up
	assign trusted_src = (cfg_access_src == PRS_TRUSTED_PORT_A) || (cfg_access_src == PRS_TRUSTED_PORT_B);

	// access filter is combinational so no access is delayed by the guard
	always_comb begin
		cfg_access_grant = 1'b0;
		cfg_access_refused = 1'b0;
		if (cfg_access_valid && !rst_any) begin
			if (guard && !trusted_src) begin
				cfg_access_refused = 1'b1;
			end else begin
				cfg_access_grant = 1'b1;
			end
		end
	end

	// next state of every register
	always_comb begin
		next_state = state;
		next_state.rdata = '0;

		// pins follow the core once out of reset, registered to keep pin timing clean
		next_state.data_pos = core_data_pos;
		next_state.data_neg = ~core_data_pos;
		next_state.strobe_pos = core_strobe_pos;
		next_state.strobe_neg = ~core_strobe_pos;
		next_state.se_data = core_se_data;
		next_state.se_strobe = core_se_strobe;
		next_state.se_enable = core_se_enable;
		next_state.gpio_data = mux_gpio_out;
		next_state.gpio_dir = mux_gpio_oe;

		// lock shows the pll, or is forced high when the pll is bypassed
		next_state.lock = lock_sync || (sel_sync == PRS_SEL_BYPASS);

		// sticky interrupt: an event in the ack cycle keeps the line up
		if (irq_ack) begin
			next_state.irq = 1'b0;
		end
		if (error_event || status_event) begin
			next_state.irq = 1'b1;
		end

		// software may override the strap defaults after reset
		if (reg_write) begin
			unique case (reg_addr)
				PRS_OFS_FEATURE: begin
					next_state.spill = reg_wdata[PRS_FB_SPILL];
					next_state.start_req = reg_wdata[PRS_FB_START_REQ];
					next_state.auto_disc = reg_wdata[PRS_FB_AUTO_DISC];
					next_state.plug_play = reg_wdata[PRS_FB_PLUG_PLAY];
					next_state.static_route = reg_wdata[PRS_FB_STATIC];
				end
				PRS_OFS_DIVISOR: begin
					next_state.init_div = reg_wdata[PRS_DB_INIT_LSB +: PRS_DIV_W];
					next_state.run_div = reg_wdata[PRS_DB_RUN_LSB +: PRS_DIV_W];
				end
				default: begin
				end
			endcase
		end

		// read data stands one cycle after the strobe, unmapped reads give zero
		if (reg_read) begin
			unique case (reg_addr)
				PRS_OFS_FEATURE: begin
					next_state.rdata[PRS_FB_SPILL] = state.spill;
					next_state.rdata[PRS_FB_START_REQ] = state.start_req;
					next_state.rdata[PRS_FB_AUTO_DISC] = state.auto_disc;
					next_state.rdata[PRS_FB_PLUG_PLAY] = state.plug_play;
					next_state.rdata[PRS_FB_STATIC] = state.static_route;
				end
				PRS_OFS_DIVISOR: begin
					next_state.rdata[PRS_DB_INIT_LSB +: PRS_DIV_W] = state.init_div;
					next_state.rdata[PRS_DB_RUN_LSB +: PRS_DIV_W] = state.run_div;
				end
				PRS_OFS_STATUS: begin
					next_state.rdata[PRS_SB_LOCK] = state.lock;
					next_state.rdata[PRS_SB_GUARD] = guard;
					next_state.rdata[PRS_SB_IRQ] = state.irq;
					next_state.rdata[PRS_SB_TEST_LSB +: PRS_TEST_W] = test_sync;
					next_state.rdata[PRS_SB_SEL_LSB +: PRS_SEL_W] = sel_sync;
					next_state.rdata[PRS_SB_DIV_LSB +: PRS_DIV_W] = div_strap;
				end
				default: begin
				end
			endcase
		end

		// reset: pins to their safe levels, straps sampled every cycle so the
		// last sample before release becomes the default
		if (rst_any) begin
			next_state.lock = 1'b0;
			next_state.irq = 1'b0;
			next_state.data_pos = PRS_RST_DIFF_POS;
			next_state.strobe_pos = PRS_RST_DIFF_POS;
			next_state.data_neg = PRS_RST_DIFF_NEG;
			next_state.strobe_neg = PRS_RST_DIFF_NEG;
			next_state.se_data = PRS_RST_SE_OUT;
			next_state.se_strobe = PRS_RST_SE_OUT;
			next_state.se_enable = PRS_RST_SE_EN;
			next_state.gpio_dir = PRS_RST_GPIO_OE;
			next_state.gpio_data = '0;
			next_state.rdata = '0;
			next_state.init_div = div_strap;
			next_state.run_div = div_strap;
			next_state.spill = strap_sync[PRS_DIV_W];
			next_state.start_req = strap_sync[PRS_DIV_W+1];
			next_state.auto_disc = strap_sync[PRS_DIV_W+2];
			next_state.plug_play = strap_sync[PRS_DIV_W+3];
			next_state.static_route = strap_sync[PRS_DIV_W+4];
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	// general pin enables also drop at once with the internal reset, which asserts
	// without waiting for a clock, so a bus fight cannot last until an edge
	assign gpio_oe = int_reset ? PRS_RST_GPIO_OE : state.gpio_dir;
	assign gpio_out = state.gpio_data;

	assign lock_out = state.lock;
	assign irq_out = state.irq;
	assign link_data_out_pos = state.data_pos;
	assign link_data_out_neg = state.data_neg;
	assign link_strobe_out_pos = state.strobe_pos;
	assign link_strobe_out_neg = state.strobe_neg;
	assign se_data_out = state.se_data;
	assign se_strobe_out = state.se_strobe;
	assign se_xcvr_enable = state.se_enable;
	assign init_divisor = state.init_div;
	assign run_divisor = state.run_div;
	assign spill_enable = state.spill;
	assign start_on_request_enable = state.start_req;
	assign auto_disconnect_enable = state.auto_disc;
	assign plug_play_enable = state.plug_play;
	assign static_route_enable = state.static_route;
	assign device_in_reset = rst_any;
	assign reg_rdata = state.rdata;
endmodule : prs_pin_reset

// *** testbench/prs_pin_reset_chk.sv ***
// assertions on the pin reset and strap loader ports
`timescale 1ns/10ps
module prs_pin_reset_chk
	import prs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic sys_reset_low,
	input wire logic [PRS_SEL_W-1:0] link_clock_select,
	input wire logic config_port_guard,
	input wire logic pll_locked,
	input wire logic lock_out,
	input wire logic irq_out,
	input wire logic [PRS_DIFF_PORTS-1:0] link_data_out_pos,
	input wire logic [PRS_DIFF_PORTS-1:0] link_data_out_neg,
	input wire logic [PRS_DIFF_PORTS-1:0] link_strobe_out_pos,
	input wire logic [PRS_DIFF_PORTS-1:0] link_strobe_out_neg,
	input wire logic [PRS_SE_PORTS-1:0] se_data_out,
	input wire logic [PRS_SE_PORTS-1:0] se_strobe_out,
	input wire logic [PRS_SE_PORTS-1:0] se_xcvr_enable,
	input wire logic [PRS_GPIO_W-1:0] gpio_oe,
	input wire logic error_event,
	input wire logic status_event,
	input wire logic irq_ack,
	input wire logic cfg_access_valid,
	input wire logic [PRS_PORT_ID_W-1:0] cfg_access_src,
	input wire logic cfg_access_grant,
	input wire logic cfg_access_refused,
	input wire logic device_in_reset
);
	logic [3:0] lk_q;
	logic any_ev;
	logic trusted;
	// lock cause kept four cycles deep so a steady cause can be tied to lock_out past the synchronisers
	always_ff @(posedge clk) begin
		lk_q <= {lk_q[2:0], pll_locked | (link_clock_select == PRS_SEL_BYPASS)};
	end
	assign any_ev = error_event | status_event;
	assign trusted = (cfg_access_src == PRS_TRUSTED_PORT_A) || (cfg_access_src == PRS_TRUSTED_PORT_B);

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_lock_reset: assert property ($past(device_in_reset) |-> !lock_out)
		else $error("lock high after a reset cycle");
	a_lock_follow: assert property (!$past(device_in_reset) && !$past(device_in_reset, 4) &&
		(lk_q[3:1] == 3'h0 || lk_q[3:1] == 3'h7) |-> lock_out == lk_q[1]) else $error("lock differs from its cause");
	a_irq_reset: assert property ($past(device_in_reset) |-> !irq_out)
		else $error("irq high after a reset cycle");
	a_irq_set: assert property (any_ev && !device_in_reset |=> irq_out || device_in_reset)
		else $error("event did not raise irq");
	a_irq_hold: assert property (irq_out && !irq_ack |=> irq_out || device_in_reset)
		else $error("irq dropped without ack");
	a_irq_clear: assert property (irq_ack && !any_ev && !device_in_reset |=> !irq_out)
		else $error("ack did not clear irq");
	a_diff_reset: assert property ($past(device_in_reset) |-> {link_data_out_pos, link_strobe_out_pos} ==
		{PRS_RST_DIFF_POS, PRS_RST_DIFF_POS} && {link_data_out_neg, link_strobe_out_neg} ==
		{PRS_RST_DIFF_NEG, PRS_RST_DIFF_NEG}) else $error("differential legs wrong in reset");
	a_se_reset: assert property ($past(device_in_reset) |-> {se_data_out, se_strobe_out, se_xcvr_enable} ==
		{PRS_RST_SE_OUT, PRS_RST_SE_OUT, PRS_RST_SE_EN}) else $error("single-ended pins wrong in reset");
	a_gpio_input: assert property (device_in_reset |-> gpio_oe == PRS_RST_GPIO_OE)
		else $error("general pin driven in reset");
	a_cfg_guard: assert property (cfg_access_valid && !device_in_reset && $past(config_port_guard, 2) &&
		$past(config_port_guard, 3) && !trusted |-> cfg_access_refused && !cfg_access_grant)
		else $error("guarded access not refused");
	a_cfg_open: assert property (cfg_access_valid && !device_in_reset && (trusted ||
		!$past(config_port_guard, 2) && !$past(config_port_guard, 3)) |-> cfg_access_grant && !cfg_access_refused)
		else $error("allowed access not granted");
	a_rst_release: assert property ($rose(sys_reset_low) |-> device_in_reset ##1 device_in_reset
		##1 !device_in_reset) else $error("internal reset release not two edges");
endmodule : prs_pin_reset_chk

bind prs_pin_reset prs_pin_reset_chk i_chk (
	.clk, .reset, .sys_reset_low, .link_clock_select, .config_port_guard, .pll_locked, .lock_out, .irq_out,
	.link_data_out_pos, .link_data_out_neg, .link_strobe_out_pos, .link_strobe_out_neg, .se_data_out,
	.se_strobe_out, .se_xcvr_enable, .gpio_oe, .error_event, .status_event, .irq_ack, .cfg_access_valid,
	.cfg_access_src, .cfg_access_grant, .cfg_access_refused, .device_in_reset
);

// *** testbench/prs_board_model.sv ***
// board strap wiring, test pins and a pll that takes a while to lock
`timescale 1ns/10ps
module prs_board_model
	import prs_pkg::*;
#(
	parameter int LOCK_CYC = 12
) (
	input wire logic clk,
	input wire logic [PRS_STRAP_W-2:0] strap_word,
	input wire logic pll_run,
	output logic [PRS_DIV_W-1:0] link_divisor_strap,
	output logic spill_strap,
	output logic start_on_request_strap,
	output logic auto_disconnect_strap,
	output logic plug_play_strap,
	output logic static_route_strap,
	output logic [PRS_TEST_W-1:0] test_mode_enable,
	output logic pll_locked
);
	int lock_cnt = 0;
	// straps are plain resistors: the chosen word lands on the pins as is
	assign {static_route_strap, plug_play_strap, auto_disconnect_strap, start_on_request_strap, spill_strap,
		link_divisor_strap} = strap_word;
	assign test_mode_enable = 2'h0; // test mode stays off for normal work
	// lock only after a full settle count; losing power drops lock on the next clock edge
	always @(posedge clk) begin
		if (!pll_run)
			lock_cnt <= 0;
		else if (lock_cnt < LOCK_CYC)
			lock_cnt <= lock_cnt + 1;
	end
	assign pll_locked = (lock_cnt == LOCK_CYC);
endmodule : prs_board_model

// *** testbench/tb_pin_reset_state_and_straps.sv ***
// self-checking bench for pin reset states and strap defaults
`timescale 1ns/10ps
module tb_pin_reset_state_and_straps
	import prs_pkg::*;
;
	localparam int LOCK_CYC = 12;
	logic clk = 1'b0;
	logic reset, sys_reset_low, config_port_guard, pll_run, pll_locked;
	logic [PRS_SEL_W-1:0] link_clock_select;
	logic [PRS_TEST_W-1:0] test_mode_enable;
	logic [PRS_DIV_W-1:0] link_divisor_strap, init_divisor, run_divisor;
	logic spill_strap, plug_play_strap, start_on_request_strap, auto_disconnect_strap, static_route_strap;
	logic [10:0] strap_word;
	logic lock_out, irq_out, error_event, status_event, irq_ack, cfg_access_valid, cfg_access_grant;
	logic cfg_access_refused, device_in_reset, reg_write, reg_read;
	logic [PRS_DIFF_PORTS-1:0] core_data_pos, core_strobe_pos, link_data_out_pos, link_data_out_neg;
	logic [PRS_DIFF_PORTS-1:0] link_strobe_out_pos, link_strobe_out_neg;
	logic [PRS_SE_PORTS-1:0] core_se_data, core_se_strobe, core_se_enable, se_data_out, se_strobe_out, se_xcvr_enable;
	logic [PRS_GPIO_W-1:0] mux_gpio_out, mux_gpio_oe, gpio_out, gpio_oe;
	logic [PRS_PORT_ID_W-1:0] cfg_access_src;
	logic spill_enable, start_on_request_enable, auto_disconnect_enable, plug_play_enable, static_route_enable;
	logic [PRS_ADDR_W-1:0] reg_addr;
	logic [PRS_DATA_W-1:0] reg_wdata, reg_rdata;
	logic [10:0] pats [3] = '{11'h7ff, 11'h2aa, 11'h555};
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	prs_board_model #(.LOCK_CYC(LOCK_CYC)) i_board (.clk, .strap_word, .pll_run, .link_divisor_strap, .spill_strap,
		.start_on_request_strap, .auto_disconnect_strap, .plug_play_strap, .static_route_strap, .test_mode_enable,
		.pll_locked);

	prs_pin_reset i_dut (.clk, .reset, .sys_reset_low, .link_clock_select, .test_mode_enable, .config_port_guard,
		.link_divisor_strap, .spill_strap, .plug_play_strap, .start_on_request_strap, .auto_disconnect_strap,
		.static_route_strap, .pll_locked, .lock_out, .irq_out, .core_data_pos, .core_strobe_pos, .link_data_out_pos,
		.link_data_out_neg, .link_strobe_out_pos, .link_strobe_out_neg, .core_se_data, .core_se_strobe,
		.core_se_enable, .se_data_out, .se_strobe_out, .se_xcvr_enable, .mux_gpio_out, .mux_gpio_oe, .gpio_out,
		.gpio_oe, .error_event, .status_event, .irq_ack, .cfg_access_valid, .cfg_access_src, .cfg_access_grant,
		.cfg_access_refused, .init_divisor, .run_divisor, .spill_enable, .start_on_request_enable,
		.auto_disconnect_enable, .plug_play_enable, .static_route_enable, .device_in_reset, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata);

	always #25 clk = ~clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : reg_wr

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_rd

	// pin reset with new straps: pin states inside, two-edge release after
	task automatic pin_reset(input logic [10:0] s);
		@(posedge clk);
		sys_reset_low <= 1'b0;
		strap_word <= s;
		#1 chk(device_in_reset, 1);
		chk(gpio_oe, 0);
		tick(4);
		#1 chk({irq_out, lock_out, se_data_out, se_strobe_out, se_xcvr_enable}, 8'h03);
		chk({link_data_out_pos, link_data_out_neg}, 32'h0000ffff);
		@(posedge clk);
		sys_reset_low <= 1'b1;
		tick(1);
		#1 chk(device_in_reset, 1);
		tick(1);
		#1 chk(device_in_reset, 0);
	endtask : pin_reset

	task automatic set_lock(input logic run, input logic [2:0] sel, input logic exp);
		@(posedge clk);
		pll_run <= run;
		link_clock_select <= sel;
		tick(LOCK_CYC + 5);
		#1 chk(lock_out, exp);
	endtask : set_lock

	task automatic ev(input logic e, input logic s, input logic a, input logic exp);
		@(posedge clk);
		{error_event, status_event, irq_ack} <= {e, s, a};
		@(posedge clk);
		{error_event, status_event, irq_ack} <= 3'h0;
		#1 chk(irq_out, exp);
	endtask : ev

	// a hang is cut short well past the roughly 180 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		logic [31:0] d;
		{sys_reset_low, config_port_guard, pll_run, error_event, status_event, irq_ack, cfg_access_valid,
			cfg_access_src, core_data_pos, core_strobe_pos, core_se_data, core_se_strobe, core_se_enable,
			mux_gpio_out, reg_write, reg_read, reg_addr, reg_wdata} = '0;
		reset = 1'b1;
		link_clock_select = 3'h1;
		mux_gpio_oe = 24'hffffff;
		strap_word = pats[0];
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		// each strap word becomes the default; moving straps afterwards must not disturb it
		foreach (pats[k]) begin
			pin_reset(pats[k]);
			@(posedge clk);
			strap_word <= ~pats[k];
			reg_rd(PRS_OFS_FEATURE, d);
			chk(d, {27'h0, pats[k][10:6]});
			reg_rd(PRS_OFS_DIVISOR, d);
			chk(d, {18'h0, pats[k][5:0], 2'h0, pats[k][5:0]});
			chk({init_divisor, run_divisor}, {pats[k][5:0], pats[k][5:0]});
			chk({static_route_enable, plug_play_enable, auto_disconnect_enable, start_on_request_enable,
				spill_enable}, pats[k][10:6]);
		end
		// no lock, lock acquired, lock lost, then pll bypass
		set_lock(1'b0, 3'h1, 1'b0);
		set_lock(1'b1, 3'h1, 1'b1);
		set_lock(1'b0, 3'h1, 1'b0);
		set_lock(1'b0, PRS_SEL_BYPASS, 1'b1);
		// guarded configuration port: only the two trusted ports pass
		@(posedge clk);
		config_port_guard <= 1'b1;
		cfg_access_valid <= 1'b1;
		tick(4);
		for (int s = 0; s < 8; s++) begin
			@(posedge clk);
			cfg_access_src <= 5'(s);
			#1 chk({cfg_access_grant, cfg_access_refused}, (s == 1 || s == 2) ? 2'h2 : 2'h1);
		end
		@(posedge clk);
		config_port_guard <= 1'b0;
		tick(4);
		#1 chk({cfg_access_grant, cfg_access_refused}, 2'h2);
		// sticky irq: event sets, event beside ack wins, lone ack clears
		ev(1'b1, 1'b0, 1'b0, 1'b1);
		ev(1'b0, 1'b1, 1'b1, 1'b1);
		ev(1'b0, 1'b0, 1'b1, 1'b0);
		ev(1'b0, 1'b1, 1'b0, 1'b1);
		// status: lock high in bypass, irq still up, live divisor strap now the low bits of ~pats[2]
		reg_rd(PRS_OFS_STATUS, d);
		chk(d, 32'h002a0005);
		// busy core outputs and a driving mux must all be overridden by a mid-run pin reset
		@(posedge clk);
		mux_gpio_oe <= 24'h0000f0;
		mux_gpio_out <= 24'ha5a5a5;
		{core_data_pos, core_strobe_pos} <= 32'h8001ffff;
		{core_se_data, core_se_strobe, core_se_enable} <= 6'h3c;
		cfg_access_valid <= 1'b0;
		tick(1);
		#1 chk(gpio_oe, 24'h0000f0);
		chk(gpio_out, 24'ha5a5a5);
		pin_reset(11'h000);
		reg_wr(8'h0c, 32'hffffffff);
		reg_rd(8'h0c, d);
		chk(d, 0);
		reg_rd(PRS_OFS_FEATURE, d);
		chk(d, 0);
		// software overrides the strap defaults; pins follow the busy core again after release
		reg_wr(PRS_OFS_FEATURE, 32'h0000001f);
		reg_wr(PRS_OFS_DIVISOR, 32'h00003f15);
		reg_rd(PRS_OFS_FEATURE, d);
		chk(d, 32'h0000001f);
		chk({init_divisor, run_divisor}, {6'h15, 6'h3f});
		chk({link_data_out_pos, link_data_out_neg}, 32'h80017ffe);
		chk({link_strobe_out_pos, link_strobe_out_neg}, 32'hffff0000);
		chk({se_data_out, se_strobe_out, se_xcvr_enable}, 6'h3c);
		report_and_stop();
	end
endmodule : tb_pin_reset_state_and_straps
